// [hdl/acr_codec_link.sv]
// codec end of the ac-link: frame engine, control registers, resets, test mode
`timescale 1ns/1ps
module acr_codec_link
    import acr_pkg::*;
#(
    parameter int INIT_CYC = acr_pkg::INIT_CYC_DFLT
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    // ac-link pins
    input wire logic COLD_RST_PIN_N,
    input wire logic SYNC,
    input wire logic SDATA_OUT,
    output logic BITCLK_O,
    output logic BITCLK_OE_N,
    output logic SDATA_IN_O,
    output logic SDATA_IN_OE_N,
    // touch converter and detectors
    input wire logic RESULT_VALID_FLAG,
    input wire logic [2:0] MEASURE_KIND,
    input wire logic [11:0] CONVERSION_VALUE,
    input wire logic JACK_INSERTED_FLAG,
    input wire logic PANEL_TOUCHED_FLAG,
    input wire logic MIC_DETECT_FLAG
);
    import acr_pkg::*;

    acr_st_t st_r;
    acr_st_t st_nxt;
    logic run;
    logic rise;
    logic fall;
    logic cold_rise;
    logic slot_en;
    logic tag12;
    logic [19:0] tx_w;
    logic [19:0] rx_w;
    logic [15:0] rdval;
    logic [15:0] pwr_v;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // the bit clock stops while power-down bit four is set; a warm pulse must not
    // restart it early, so the clock stays low until sync has fallen
    assign run = !(st_r.regs[I_PWR][PR4_BIT] && st_r.cold_s);
    assign rise = CLK_EN && run && (st_r.div == DIV_RISE);
    assign fall = CLK_EN && run && (st_r.div == DIV_FALL);
    assign cold_rise = CLK_EN && st_r.cold_s && !st_r.cold_d;
    assign slot_en = st_r.regs[I_CONV_B][0];
    assign tag12 = (st_r.regs[I_CONV_A][7:6] != 2'h0) && slot_en
        && (st_r.regs[I_CONV_B][2:1] == CHOICE_S12);
    assign rx_w = {st_r.sh[18:0], st_r.sdo_s};
    assign pwr_v = st_r.regs[I_PWR];

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    always_comb begin
        rdval = 16'h0000;
        if (st_r.rd_addr == A_CAPS) begin
            rdval = CAPS_VAL;
        end else if (st_r.rd_addr == A_EXT_CAPS) begin
            rdval = EXT_CAPS_VAL;
        end else if (st_r.rd_addr == A_DETECT) begin
            rdval = {13'h0000, PANEL_TOUCHED_FLAG, JACK_INSERTED_FLAG, MIC_DETECT_FLAG};
        end else if (st_r.rd_addr == A_RES_A) begin
            rdval = {RESULT_VALID_FLAG, MEASURE_KIND, CONVERSION_VALUE};
        end else if (st_r.rd_addr == A_RES_B || st_r.rd_addr == A_RES_C) begin
            rdval = 16'h0000;
        end else if (st_r.rd_addr == A_ID_HI) begin
            rdval = ID_HI_VAL;
        end else if (st_r.rd_addr == A_ID_LO) begin
            rdval = ID_LO_VAL;
        end else begin
            for (int i = 0; i < NRW; i++) begin
                if (RW_ADDR[i] == st_r.rd_addr) begin
                    rdval = st_r.regs[i];
                end
            end
            // ready flags follow the powered blocks once initialised
            if (st_r.rd_addr == RW_ADDR[I_PWR]) begin
                rdval[2:0] = {3{st_r.ready}} & ~pwr_v[10:8];
            end
        end
    end

    // ------------------------------------------------------------
    // outgoing slot words
    // ------------------------------------------------------------
    always_comb begin
        tx_w = 20'h0_0000;
        case (st_r.slot)
            4'h0: begin
                tx_w[15] = st_r.ready;
                tx_w[14] = st_r.resp;
                tx_w[13] = st_r.resp;
                tx_w[3] = tag12;
            end
            4'h1: begin
                if (st_r.resp) begin
                    tx_w[18:12] = st_r.resp_addr;
                end
            end
            4'h2: begin
                if (st_r.resp) begin
                    tx_w[19:4] = st_r.resp_data;
                end
            end
            SLOT_TOUCH: begin
                if (slot_en) begin
                    if (st_r.regs[I_CONV_B][2:1] == CHOICE_S12) begin
                        tx_w[19:4] = {RESULT_VALID_FLAG, MEASURE_KIND,
                            CONVERSION_VALUE};
                    end
                    tx_w[1] = JACK_INSERTED_FLAG;
                    tx_w[0] = PANEL_TOUCHED_FLAG;
                end
            end
            // slots 3 to 11 carry nothing from this block
            default: begin
                tx_w = 20'h0_0000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (CLK_EN) begin
            // pins cross two flops before use
            st_nxt.cold_m = COLD_RST_PIN_N;
            st_nxt.cold_s = st_r.cold_m;
            st_nxt.cold_d = st_r.cold_s;
            st_nxt.sync_m = SYNC;
            st_nxt.sync_s = st_r.sync_m;
            st_nxt.sdo_m = SDATA_OUT;
            st_nxt.sdo_s = st_r.sdo_m;
            if (run) begin
                st_nxt.div = st_r.div + 3'h1;
                st_nxt.bclk = (st_r.div == DIV_RISE) ? 1'b1 :
                    (st_r.div == DIV_FALL) ? 1'b0 : st_r.bclk;
            end else begin
                st_nxt.bclk = 1'b0;
            end
            // warm reset: sync pulse while the clock is stopped
            if (!run && st_r.sync_s) begin
                st_nxt.warm = 1'b1;
            end
            if (st_r.warm && !st_r.sync_s) begin
                st_nxt.warm = 1'b0;
                st_nxt.regs[I_PWR][PR4_BIT] = 1'b0;
                st_nxt.regs[I_PWR][PR5_BIT] = 1'b0;
                st_nxt.div = 3'h0;
            end
        end
        // ------------------------------------------------------------
        // receive side, on the falling bit clock edge
        // ------------------------------------------------------------
        if (fall) begin
            st_nxt.sync_d = st_r.sync_s;
            if (st_r.sync_s && !st_r.sync_d) begin
                st_nxt.slot = 4'h0;
                st_nxt.pos = POS_TAG;
                // a read answered in the frame after the command
                st_nxt.resp = st_r.rd_req;
                st_nxt.resp_addr = st_r.rd_addr;
                st_nxt.resp_data = rdval;
                st_nxt.rd_req = 1'b0;
            end else if (st_r.pos == 5'h00) begin
                st_nxt.pos = POS_TOP;
                if (st_r.slot != SLOT_IDLE) begin
                    st_nxt.slot = st_r.slot + 4'h1;
                end
            end else begin
                st_nxt.pos = st_r.pos - 5'h01;
            end
        end
        if (fall && st_nxt.slot != SLOT_IDLE) begin
            st_nxt.sh = {st_r.sh[18:0], st_r.sdo_s};
            if (st_nxt.pos == 5'h00) begin
                case (st_nxt.slot)
                    4'h0: st_nxt.tag = rx_w[15:13];
                    4'h1: st_nxt.cmd = rx_w;
                    4'h2: begin
                        if (st_r.tag[2] && st_r.tag[1]) begin
                            if (st_r.cmd[19]) begin
                                st_nxt.rd_req = 1'b1;
                                st_nxt.rd_addr = st_r.cmd[18:12];
                            end else if (st_r.tag[0]) begin
                                for (int i = 0; i < NRW; i++) begin
                                    if (RW_ADDR[i] == st_r.cmd[18:12]) begin
                                        st_nxt.regs[i] = (st_r.regs[i] & ~RW_MASK[i])
                                            | (rx_w[19:4] & RW_MASK[i]);
                                    end
                                end
                            end
                        end
                    end
                    default: st_nxt.tag = st_r.tag;
                endcase
            end
        end
        // ------------------------------------------------------------
        // transmit side, on the rising bit clock edge
        // ------------------------------------------------------------
        if (rise) begin
            st_nxt.sdi = (st_r.slot == SLOT_IDLE) ? 1'b0 : tx_w[st_r.pos];
        end
        // ------------------------------------------------------------
        // cold reset, initialisation and test mode
        // ------------------------------------------------------------
        if (CLK_EN && !st_r.cold_s) begin
            st_nxt.regs = RW_RST;
            st_nxt.ready = 1'b0;
            st_nxt.init = '0;
            st_nxt.warm = 1'b0;
            st_nxt.rd_req = 1'b0;
            st_nxt.resp = 1'b0;
            st_nxt.slot = SLOT_IDLE;
        end else if (CLK_EN && !st_r.ready && !st_r.test) begin
            st_nxt.init = st_r.init + 19'h0_0001;
            if (st_r.init == INIT_W'(INIT_CYC - 1)) begin
                st_nxt.ready = 1'b1;
            end
        end
        if (cold_rise) begin
            // leaving test needs both sync and data out low
            st_nxt.test = st_r.sdo_s || (st_r.test && st_r.sync_s);
            st_nxt.init = '0;
        end
        st_nxt.oe_n = st_nxt.test;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_r <= '0;
            st_r.regs <= RW_RST;
            st_r.slot <= SLOT_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign BITCLK_O = st_r.bclk;
    assign BITCLK_OE_N = st_r.oe_n;
    assign SDATA_IN_O = st_r.sdi;
    assign SDATA_IN_OE_N = st_r.oe_n;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    a_reserved_zero: assert property (
        rise && st_r.slot inside {[4'h7:4'hb]} |=> !SDATA_IN_O)
        else $error("reserved slot not zero");
    a_touch_gate: assert property (
        rise && st_r.slot == SLOT_TOUCH && !slot_en |=> !SDATA_IN_O)
        else $error("slot 12 driven while disabled");
    a_touch_flag: assert property (
        rise && st_r.slot == SLOT_TOUCH && st_r.pos == 5'h00 && slot_en
        |=> SDATA_IN_O == $past(PANEL_TOUCHED_FLAG)) else $error("touch flag wrong");
    a_jack_flag: assert property (
        rise && st_r.slot == SLOT_TOUCH && st_r.pos == 5'h01 && slot_en
        |=> SDATA_IN_O == $past(JACK_INSERTED_FLAG)) else $error("jack flag wrong");
    a_pad_zero: assert property (
        rise && st_r.slot == SLOT_TOUCH && st_r.pos inside {5'h02, 5'h03}
        |=> !SDATA_IN_O) else $error("slot 12 pad bits not zero");
    a_tag_forced: assert property (
        rise && st_r.slot == 4'h0 && st_r.pos == 5'h03 && tag12 |=> SDATA_IN_O)
        else $error("slot 12 tag not valid");
    a_ready_low: assert property (
        CLK_EN && !st_r.cold_s |=> !st_r.ready)
        else $error("ready during reset");
    a_init_len: assert property (
        $rose(st_r.ready) |-> $past(st_r.init) == INIT_W'(INIT_CYC - 1))
        else $error("initialisation length wrong");
    a_regs_dflt: assert property (
        CLK_EN && !st_r.cold_s |=> st_r.regs == RW_RST && run)
        else $error("defaults not restored");
    a_warm_clear: assert property (
        CLK_EN && st_r.warm && !st_r.sync_s && st_r.cold_s
        |=> pwr_v[13:12] == 2'h0 && $stable(pwr_v[11:8]) && $stable(pwr_v[14]))
        else $error("warm reset bits wrong");
    a_warm_hold: assert property (
        CLK_EN && st_r.warm && st_r.sync_s && st_r.cold_s |=> !BITCLK_O)
        else $error("bit clock ran during warm pulse");
    a_clk_stop: assert property (
        CLK_EN && !run ##1 !run |-> !BITCLK_O)
        else $error("bit clock runs while stopped");
    a_test_entry: assert property (
        cold_rise && st_r.sdo_s |=> st_r.test ##1 SDATA_IN_OE_N && BITCLK_OE_N)
        else $error("test mode not entered");
    a_test_off: assert property (
        st_r.test |-> BITCLK_OE_N && SDATA_IN_OE_N)
        else $error("link driven in test mode");
    a_test_keep: assert property (
        st_r.test && cold_rise && !st_r.sdo_s && st_r.sync_s |=> st_r.test)
        else $error("test mode left wrongly");
    a_test_exit: assert property (
        st_r.test && cold_rise && !st_r.sdo_s && !st_r.sync_s |=> !st_r.test)
        else $error("test mode not left");
    // a read answer goes out in one frame only
    a_resp_once: assert property (
        fall && st_r.sync_s && !st_r.sync_d && !st_r.rd_req |=> !st_r.resp)
        else $error("read answer repeated");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    c_warm_reset: cover property (st_r.warm ##[1:50] !st_r.warm);
    c_test_mode: cover property (cold_rise && st_r.sdo_s);
    c_read_resp: cover property (fall && st_nxt.resp && !st_r.resp);
    c_ready: cover property ($rose(st_r.ready));
    c_slot12_result: cover property (rise && st_r.slot == SLOT_TOUCH && slot_en
        && st_r.regs[I_CONV_B][2:1] == CHOICE_S12);
endmodule // acr_codec_link

// [hdl/acr_pkg.sv]
// constants, register table and state type of the ac-link codec block
package acr_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 20000000;
    localparam longint FS_HZ = 48000;
    localparam longint INIT_TS = 1028;
    // least time: round up to whole cycles
    localparam int INIT_CYC_DFLT = int'((INIT_TS * CLK_HZ + FS_HZ - 1) / FS_HZ);
    localparam int INIT_W = 19;
    // bit clock = clk / 8, edges at fixed divider phases
    localparam logic [2:0] DIV_RISE = 3'h3;
    localparam logic [2:0] DIV_FALL = 3'h7;
    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam logic [3:0] SLOT_IDLE = 4'hd;
    localparam logic [3:0] SLOT_TOUCH = 4'hc;
    localparam logic [4:0] POS_TAG = 5'h0f;
    localparam logic [4:0] POS_TOP = 5'h13;
    localparam logic [1:0] CHOICE_S12 = 2'h2;
    // ------------------------------------------------------------
    // register table
    // ------------------------------------------------------------
    localparam int NRW = 22;
    localparam int I_PWR = 11;
    localparam int I_CONV_A = 20;
    localparam int I_CONV_B = 21;
    localparam int PR4_BIT = 12;
    localparam int PR5_BIT = 13;
    localparam logic [6:0] A_CAPS = 7'h00;
    localparam logic [6:0] A_EXT_CAPS = 7'h28;
    localparam logic [6:0] A_DETECT = 7'h6a;
    localparam logic [6:0] A_RES_A = 7'h74;
    localparam logic [6:0] A_RES_B = 7'h76;
    localparam logic [6:0] A_RES_C = 7'h78;
    localparam logic [6:0] A_ID_HI = 7'h7c;
    localparam logic [6:0] A_ID_LO = 7'h7e;
    localparam logic [15:0] CAPS_VAL = 16'h0030;
    localparam logic [15:0] EXT_CAPS_VAL = 16'h0001;
    // maker codes: arbitrary neutral values
    localparam logic [15:0] ID_HI_VAL = 16'h1234;
    localparam logic [15:0] ID_LO_VAL = 16'h5678;
    // highest index first
    localparam logic [NRW-1:0][6:0] RW_ADDR = {
        7'h72, 7'h70, 7'h68, 7'h66, 7'h64, 7'h62, 7'h60, 7'h32, 7'h2c, 7'h2a, 7'h26,
        7'h20, 7'h1a, 7'h18, 7'h10, 7'h0e, 7'h0c, 7'h0a, 7'h08, 7'h06, 7'h04, 7'h02};
    localparam logic [NRW-1:0][15:0] RW_RST = {
        16'h9400, 16'h0001, 16'h0002, 16'h0000, 16'h2d21, 16'h0103, 16'h0000,
        16'hbb80, 16'hbb80, 16'h0000, 16'h0300, 16'h0000, 16'h0200, 16'h0000,
        16'h8808, 16'h8008, 16'h8008, 16'h8000, 16'h0000, 16'h8000, 16'h8000,
        16'h8000};
    localparam logic [NRW-1:0][15:0] RW_MASK = {
        16'h7e07, 16'hffff, 16'h001f, 16'h7f7f, 16'h7fff, 16'h8fff, 16'hc1ff,
        16'hffff, 16'hffff, 16'h0001, 16'h7f00, 16'h0380, 16'h0300, 16'hff7f,
        16'h9f1f, 16'h807f, 16'h801f, 16'h8000, 16'h0c00, 16'h8007, 16'h8000,
        16'h8000};
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic cold_m, cold_s, cold_d;
        logic sync_m, sync_s, sync_d;
        logic sdo_m, sdo_s;
        logic [2:0] div;
        logic bclk, sdi, oe_n, test, warm, ready;
        logic [INIT_W-1:0] init;
        logic [3:0] slot;
        logic [4:0] pos;
        logic [19:0] sh;
        logic [2:0] tag;
        logic [19:0] cmd;
        logic rd_req, resp;
        logic [6:0] rd_addr, resp_addr;
        logic [15:0] resp_data;
        logic [NRW-1:0][15:0] regs;
    } acr_st_t;
endpackage

// [bench/acr_ctrl_model.sv]
// controller-side model of the ac-link: frames, cold and warm resets
`timescale 1ns/1ps
module acr_ctrl_model (
    // link from the codec
    input wire logic bitclk,
    input wire logic sdata_in,
    // controller pins
    output logic cold_rst_pin_n,
    output logic sync,
    output logic sdata_out
);
    logic [255:0] rx;
    initial begin
        cold_rst_pin_n = 1'b0;
        sync = 1'b0;
        sdata_out = 1'b0;
        rx = '0;
    end
    // nb below 256 ends early, where the bit clock is known to stop mid-frame
    task automatic frame(input logic [255:0] tx, input int nb);
        for (int i = 0; i <= nb; i++) begin
            @(posedge bitclk);
            #5;
            sync = (i < 16);
            sdata_out = (i < nb) ? tx[255-i] : 1'b0;
            @(negedge bitclk);
            if (i > 0) rx[256-i] = sdata_in;
        end
    endtask
    // levels of sync and data at the pin's rise pick normal or test mode
    task automatic cold(input logic s, input logic d);
        cold_rst_pin_n = 1'b0;
        #2000;
        sync = s;
        sdata_out = d;
        #400;
        cold_rst_pin_n = 1'b1;
        #400;
        sync = 1'b0;
        sdata_out = 1'b0;
    endtask
    task automatic warm();
        sync = 1'b1;
        #300;
        sync = 1'b0;
    endtask
endmodule // acr_ctrl_model

// [bench/aclink_codec_reset_and_regmap_tb.sv]
// self-checking bench of the ac-link codec block
`timescale 1ns/1ps
module aclink_codec_reset_and_regmap_tb;
    import acr_pkg::*;
    // ------------------------------------------------------------
    // pins, shadow registers, bookkeeping
    // ------------------------------------------------------------
    logic mclk, sys_rst, clk_en, rv, jk, pt, mic, rdy, pend;
    logic [2:0] mk;
    logic [11:0] cv;
    logic [6:0] pa;
    logic bclk_o, bclk_oe_n, sdi_o, sdi_oe_n, bclk_k, sdi_k;
    wire logic rst_n, sync, sdo, bclk_w, sdi_w;
    logic [15:0] sh [128];
    logic [15:0] msk [128];
    logic [31:0] r;
    int seed, n_mismatch, compares, r0;
    int cyc = 0;
    int n_rise = 0;
    localparam logic [8:0][6:0] XA = {A_CAPS, A_EXT_CAPS, A_DETECT, A_RES_A, A_RES_B,
        A_ID_HI, A_ID_LO, 7'h01, 7'h40};
    // a released line shows the inverse of its last driven level
    always @* if (!bclk_oe_n) bclk_k = bclk_o;
    always @* if (!sdi_oe_n) sdi_k = sdi_o;
    assign bclk_w = bclk_oe_n ? ~bclk_k : bclk_o;
    assign sdi_w = sdi_oe_n ? ~sdi_k : sdi_o;
    always #25 mclk = ~mclk;
    always @(posedge bclk_o) n_rise++;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 110000) begin
            n_mismatch++;
            results();
        end
    end
    acr_codec_link #(.INIT_CYC(40)) acr_codec_link_inst (
        .MCLK(mclk), .SYS_RST(sys_rst), .CLK_EN(clk_en), .COLD_RST_PIN_N(rst_n),
        .SYNC(sync), .SDATA_OUT(sdo), .BITCLK_O(bclk_o), .BITCLK_OE_N(bclk_oe_n),
        .SDATA_IN_O(sdi_o), .SDATA_IN_OE_N(sdi_oe_n), .RESULT_VALID_FLAG(rv),
        .MEASURE_KIND(mk), .CONVERSION_VALUE(cv), .JACK_INSERTED_FLAG(jk),
        .PANEL_TOUCHED_FLAG(pt), .MIC_DETECT_FLAG(mic));
    acr_ctrl_model acr_ctrl_model_inst (.bitclk(bclk_w), .sdata_in(sdi_w),
        .cold_rst_pin_n(rst_n), .sync(sync), .sdata_out(sdo));
    task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results();
        if (n_mismatch == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic sh_reset();
        for (int i = 0; i < 128; i++) begin
            sh[i] = '0;
            msk[i] = '0;
        end
        for (int i = 0; i < NRW; i++) begin
            sh[RW_ADDR[i]] = RW_RST[i];
            msk[RW_ADDR[i]] = RW_MASK[i];
        end
        sh[A_CAPS] = CAPS_VAL;
        sh[A_EXT_CAPS] = EXT_CAPS_VAL;
        sh[A_ID_HI] = ID_HI_VAL;
        sh[A_ID_LO] = ID_LO_VAL;
        pend = 1'b0;
        rdy = 1'b0;
    endtask
    function automatic logic [15:0] exp_rd(input logic [6:0] a);
        if (a == 7'h26) return {sh[a][15:3], ~sh[a][10:8] & {3{rdy}}};
        if (a == A_DETECT) return {13'h0, pt, jk, mic};
        if (a == A_RES_A) return {rv, mk, cv};
        return sh[a];
    endfunction
    // one frame: op 0 idle, 1 write, 2 read; a cut-short frame is not checked
    task automatic xfer(input logic [1:0] op, input logic [6:0] a, input logic [15:0] d,
        input int nb);
        logic [255:0] tx;
        logic [255:0] got;
        logic [19:0] s12;
        logic t3;
        tx = '0;
        tx[255:240] = (op == 2'd1) ? 16'he000 : (op == 2'd2) ? 16'hc000 : 16'h0000;
        tx[239:220] = {op == 2'd2, a, 12'h000};
        tx[219:200] = {d, 4'h0};
        @(posedge mclk);
        #5;
        if (op == 2'd1) begin
            r = $random(seed);
            {rv, mk, cv, jk, pt, mic} = r[18:0];
        end
        t3 = sh[7'h70][7:6] != 2'b00 && sh[7'h72][0] && sh[7'h72][2:1] == CHOICE_S12;
        acr_ctrl_model_inst.frame(tx, nb);
        got = acr_ctrl_model_inst.rx;
        if (op == 2'd1) sh[a] = (sh[a] & ~msk[a]) | (d & msk[a]);
        s12 = '0;
        if (sh[7'h72][0]) s12[1:0] = {jk, pt};
        if (sh[7'h72][0] && sh[7'h72][2:1] == CHOICE_S12) s12[19:4] = {rv, mk, cv};
        if (nb == 256) begin
            chk("ready", rdy, got[255]);
            chk("tags", {pend, pend, t3}, {got[254:253], got[243]});
            chk("slot1", pend ? {1'b0, pa, 12'h000} : 20'h0, got[239:220]);
            chk("slot2", pend ? {exp_rd(pa), 4'h0} : 20'h0, got[219:200]);
            chk("slots3_11", 20'h0, {19'h0, |got[199:20]});
            chk("slot12", s12, got[19:0]);
        end
        pend = (op == 2'd2);
        pa = a;
    endtask
    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        {rv, mk, cv, jk, pt, mic} = '0;
        seed = 96;
        n_mismatch = 0;
        compares = 0;
        sh_reset();
        repeat (4) @(posedge mclk);
        #5;
        sys_rst = 1'b0;
        fork
            acr_ctrl_model_inst.cold(1'b0, 1'b0);
            begin
                #500;
                r0 = n_rise;
                #1400;
                chk("clock_in_reset", 20'h1, {19'h0, n_rise > r0 + 2});
            end
        join
        xfer(2'd0, 7'h0, 16'h0, 256);
        rdy = 1'b1;
        r = $random(seed);
        xfer(2'd1, 7'h70, {r[15:8], 2'b10, r[5:0]}, 256);
        for (int k = 0; k < 8; k++) begin
            r = $random(seed);
            xfer(2'd1, 7'h72, {r[15:3], 3'(k)}, 256);
        end
        xfer(2'd1, A_CAPS, 16'hffff, 256);
        xfer(2'd2, A_CAPS, 16'h0, 256);
        xfer(2'd2, 7'h70, 16'h0, 256);
        xfer(2'd2, 7'h72, 16'h0, 256);
        xfer(2'd0, 7'h0, 16'h0, 256);
        // power-down stops the bit clock mid-frame; a sync pulse or a cold reset wakes it
        xfer(2'd1, 7'h26, 16'h7f00, 55);
        r0 = n_rise;
        repeat (40) @(posedge mclk);
        acr_ctrl_model_inst.warm();
        chk("clock_stopped", 20'h0, 20'(n_rise - r0));
        repeat (20) @(posedge mclk);
        chk("clock_restart", 20'h1, {19'h0, n_rise > r0});
        sh[7'h26] = sh[7'h26] & ~16'h3000;
        xfer(2'd2, 7'h26, 16'h0, 256);
        xfer(2'd0, 7'h0, 16'h0, 256);
        acr_ctrl_model_inst.cold(1'b1, 1'b1);
        chk("test_entry", 20'h3, {18'h0, bclk_oe_n, sdi_oe_n});
        acr_ctrl_model_inst.cold(1'b1, 1'b0);
        chk("test_held", 20'h3, {18'h0, bclk_oe_n, sdi_oe_n});
        acr_ctrl_model_inst.cold(1'b0, 1'b0);
        chk("test_exit", 20'h0, {18'h0, bclk_oe_n, sdi_oe_n});
        sh_reset();
        xfer(2'd0, 7'h0, 16'h0, 256);
        rdy = 1'b1;
        for (int i = 0; i < NRW; i++) xfer(2'd2, RW_ADDR[i], 16'h0, 256);
        for (int i = 0; i < 9; i++) xfer(2'd2, XA[i], 16'h0, 256);
        xfer(2'd0, 7'h0, 16'h0, 256);
        results();
    end
endmodule // aclink_codec_reset_and_regmap_tb
